/* File: logic/deadtime_channel.sv */
// Dead-time inserter for one complementary output pair
`include "prot_params.svh"

module deadtime_channel
	import prot_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	input  wire logic       ref_in,
	input  wire logic [9:0] dt_cycles_in,
	output logic            true_level_out,
	output logic            compl_level_out
);

	dt_state_type s;
	dt_state_type next_s;

	////////////////////////////////////////////////////////////////////////
	// Edge of reference restarts the gap; both stay low until it ends
	always_comb
	begin
		next_s = s;
		next_s.prev_ref = ref_in;
		if (ref_in != s.prev_ref)
			next_s.cnt = dt_cycles_in;
		else if (s.cnt != 10'h000)
			next_s.cnt = s.cnt - 10'h001;
		// (R15) gap between pair
		next_s.true_level  = ref_in && (next_s.cnt == 10'h000);
		next_s.compl_level = !ref_in && (next_s.cnt == 10'h000);
	end

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			s <= '0;
		else
			s <= next_s;
	end

	assign true_level_out  = s.true_level;
	assign compl_level_out = s.compl_level;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	property p_never_both;
		!(s.true_level && s.compl_level);
	endproperty
	a_never_both: assert property (p_never_both) // (R15)
		else $error("true and complementary high together");

	sequence rise_with_gap;
		$rose(ref_in) && dt_cycles_in == 10'h003 && $stable(dt_cycles_in);
	endsequence
	property p_gap_length;
		rise_with_gap ##1 ref_in [*3] |-> !s.true_level ##1 s.true_level;
	endproperty
	a_gap_length: assert property (p_gap_length) // (R15)
		else $error("dead time not three cycles");

endmodule : deadtime_channel

/* File: logic/output_protection.sv */
// Output protection: off-states, configuration lock and dead time
//
// Function
// (R1) Run off-state only with outputs enabled, complementary
// (R2) No run off-state without complementary outputs
// (R3) Run off-state 0 disables inactive outputs
// (R4) Run off-state 1 drives inactive level
// (R5) Idle off-state only with outputs disabled
// (R6) Idle off-state 1 forces idle level
// (R7) Lock level 2 freezes off-state bits
// (R8) Lock 00 leaves everything writable
// (R9) Lock 01 freezes dead time, idle, break
// (R10) Lock 10 adds polarity and off-state bits
// (R11) Lock 11 adds compare mode and preload
// (R12) Lock field written once after reset
// (R13) Dead time linear and double-tick ranges
// (R14) Dead time eight and sixteen tick ranges
// (R15) Dead time between true and complementary
// (R16) Dead time frozen at lock levels 1 to 3
// (R17) Registers decoded as 16-bit registers
// (R18) Break clears main output enable
// (R19) Main enable gates channel enables
// (R20) Locked fields kept, others still written
// (R21) Software programs lockable fields first write
`include "prot_params.svh"

module output_protection
	import prot_pkg::*;
#(
	parameter bit has_complementary = 1'b1
)
(
	input  wire logic          clk_in,
	input  wire logic          rstn_in,
	input  wire reg_req_type   reg_req_in,
	input  wire logic [2:0]    ref_in,
	input  wire logic          break_in,
	input  wire logic          update_event_in,
	output logic [15:0]        rdata_out,
	output pin_group_type      pins_out,
	output logic               main_output_enable_out
);

	prot_state_type s;
	prot_state_type next_s;
	logic [2:0]     dt_true;
	logic [2:0]     dt_compl;

	////////////////////////////////////////////////////////////////////////
	// Channel is an output when its direction select is 00
	function automatic logic is_output(input logic [23:0] mode, input int ch);
		return mode[8*ch +: 2] == 2'b00;
	endfunction : is_output

	// (R13) range decode of dead time
	function automatic logic [9:0] dt_ticks(input logic [7:0] g);
		logic [9:0] t;
		t = 10'h000;
		if (!g[7])
			t = {2'b00, g};
		else if (g[7:6] == 2'b10)
			t = 10'({4'h1, g[5:0]}) << 1;
		else if (g[7:5] == 3'b110)
			// (R14) eight tick range
			t = 10'({2'b01, g[4:0]}) << 3;
		else
			t = 10'({2'b01, g[4:0]}) << 4;
		return t;
	endfunction : dt_ticks

	////////////////////////////////////////////////////////////////////////
	// One dead-time inserter per channel
	genvar gi;
	generate
		for (gi = 0; gi < `CHANNEL_COUNT; gi++)
		begin : g_dt
			deadtime_channel u_dt (
				.clk_in          (clk_in),
				.rstn_in         (rstn_in),
				.ref_in          (ref_in[gi]),
				.dt_cycles_in    (s.dt_cycles),
				.true_level_out  (dt_true[gi]),
				.compl_level_out (dt_compl[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Register writes, lock filtering, main enable and output stage
	always_comb
	begin
		logic [1:0]  lock;
		logic [15:0] w;
		logic        brk_active;
		logic        e, ne, p, np, main_output_enable;
		next_s = s;
		e = 1'b0;
		ne = 1'b0;
		p = 1'b0;
		np = 1'b0;
		main_output_enable = s.bdt[`BDT_MAIN_OE_BIT];
		lock = s.bdt[`BDT_LOCK_LSB +: 2];
		w = reg_req_in.wdata;
		brk_active = s.bdt[`BDT_BRK_EN_BIT] &&
			(break_in == s.bdt[`BDT_BRK_POL_BIT]);
		next_s.rdata = 16'h0000;

		// (R17) 16-bit register writes
		if (reg_req_in.wr)
		begin
			unique case (reg_req_in.addr)
				`TIMER_CONTROL_TWO_ADDR:
				begin
					// (R9) idle bits lock at level 1
					if (lock == 2'b00)
						next_s.idle_state = w[`IDLE_STATE_LSB +: 6];
				end
				`CHANNEL_ENABLE_ADDR:
				begin
					for (int c = 0; c < `CHANNEL_COUNT; c++)
					begin
						next_s.chan_enable[4*c]     = w[4*c];
						next_s.chan_enable[4*c + 2] = w[4*c + 2];
						// (R10) polarity kept at level 2
						if (!(lock[1] && is_output(s.chan_mode, c)))
						begin
							next_s.chan_enable[4*c + 1] = w[4*c + 1];
							next_s.chan_enable[4*c + 3] = w[4*c + 3];
						end
					end
				end
				`CHANNEL_MODE_ONE_ADDR, `CHANNEL_MODE_TWO_ADDR:
				begin
					for (int c = 0; c < `CHANNEL_COUNT; c++)
					begin
						if ((c / 2 == 1) ==
							(reg_req_in.addr == `CHANNEL_MODE_TWO_ADDR))
						begin
							// (R20) lock keeps only protected bits
							next_s.chan_mode[8*c +: 8] = w[8*(c % 2) +: 8];
							// (R11) mode and preload kept at level 3
							if (lock == 2'b11 && is_output(s.chan_mode, c))
								next_s.chan_mode[8*c + 3 +: 4] =
									s.chan_mode[8*c + 3 +: 4];
						end
					end
				end
				`BREAK_DEADTIME_CONTROL_ADDR:
				begin
					next_s.bdt[`BDT_MAIN_OE_BIT] = w[`BDT_MAIN_OE_BIT];
					// (R8) level 0 allows all
					// (R9) break and auto enable locked at level 1
					// (R16) dead time locked at levels 1 to 3
					if (lock == 2'b00)
					begin
						next_s.bdt[`BDT_AUTO_OE_BIT] = w[`BDT_AUTO_OE_BIT];
						next_s.bdt[`BDT_BRK_POL_BIT] = w[`BDT_BRK_POL_BIT];
						next_s.bdt[`BDT_BRK_EN_BIT]  = w[`BDT_BRK_EN_BIT];
						next_s.bdt[`BDT_DTG_LSB +: 8] = w[`BDT_DTG_LSB +: 8];
					end
					// (R7) off-state bits locked at level 2
					if (!lock[1])
					begin
						next_s.bdt[`BDT_IDLE_OFF_BIT] = w[`BDT_IDLE_OFF_BIT];
						// (R2) run off-state absent without pairs
						next_s.bdt[`BDT_RUN_OFF_BIT] =
							w[`BDT_RUN_OFF_BIT] && has_complementary;
					end
					// (R12) lock taken on first write only
					if (!s.bdt_written)
						next_s.bdt[`BDT_LOCK_LSB +: 2] = w[`BDT_LOCK_LSB +: 2];
					next_s.bdt_written = 1'b1;
				end
				default: ;
			endcase
		end

		// (R18) break wins over any set of main enable
		if (brk_active)
			next_s.bdt[`BDT_MAIN_OE_BIT] = 1'b0;
		else if (s.bdt[`BDT_AUTO_OE_BIT] && update_event_in)
			next_s.bdt[`BDT_MAIN_OE_BIT] = 1'b1;

		// Read data stands only in the cycle after the strobe
		if (reg_req_in.rd)
		begin
			unique case (reg_req_in.addr)
				`TIMER_CONTROL_TWO_ADDR:
					next_s.rdata = {2'b00, s.idle_state, 8'h00};
				`CHANNEL_ENABLE_ADDR:
					next_s.rdata = {4'h0, s.chan_enable};
				`CHANNEL_MODE_ONE_ADDR:
					next_s.rdata = s.chan_mode[15:0];
				`CHANNEL_MODE_TWO_ADDR:
					next_s.rdata = {8'h00, s.chan_mode[23:16]};
				`BREAK_DEADTIME_CONTROL_ADDR:
					next_s.rdata = s.bdt;
				default:
					next_s.rdata = 16'h0000;
			endcase
		end

		// Dead time registered so the inserters see a settled count
		next_s.dt_cycles = 10'(dt_ticks(s.bdt[`BDT_DTG_LSB +: 8]) *
			`DEADTIME_TICK_CYCLES);

		// Output stage per channel
		for (int c = 0; c < `CHANNEL_COUNT; c++)
		begin
			e  = s.chan_enable[4*c];
			p  = s.chan_enable[4*c + 1];
			ne = s.chan_enable[4*c + 2] && has_complementary;
			np = s.chan_enable[4*c + 3];
			next_s.pins.true_output[c]             = 1'b0;
			next_s.pins.complementary_output[c]    = 1'b0;
			next_s.pins.true_output_oe[c]          = 1'b0;
			next_s.pins.complementary_output_oe[c] = 1'b0;
			if (!is_output(s.chan_mode, c))
			begin
			end
			// (R19) main enable gates channel enables
			else if (main_output_enable)
			begin
				if (e && ne)
				begin
					// (R15) pair with dead time
					next_s.pins.true_output[c] = dt_true[c] ^ p;
					next_s.pins.complementary_output[c] = dt_compl[c] ^ np;
					next_s.pins.true_output_oe[c] = 1'b1;
					next_s.pins.complementary_output_oe[c] = 1'b1;
				end
				else if (e || ne)
				begin
					// (R1) run off-state on the idle half
					// (R3) off-state 0 releases it
					// (R4) off-state 1 drives inactive level
					next_s.pins.true_output[c] = e ? (ref_in[c] ^ p) : p;
					next_s.pins.complementary_output[c] =
						ne ? (ref_in[c] ^ np) : np;
					next_s.pins.true_output_oe[c] =
						e || s.bdt[`BDT_RUN_OFF_BIT];
					next_s.pins.complementary_output_oe[c] =
						ne || s.bdt[`BDT_RUN_OFF_BIT];
				end
			end
			// (R5) idle off-state with main enable low
			// (R6) idle level forced when selected
			else if ((e || ne) && s.bdt[`BDT_IDLE_OFF_BIT])
			begin
				next_s.pins.true_output[c] = s.idle_state[2*c];
				next_s.pins.complementary_output[c] = s.idle_state[2*c + 1];
				next_s.pins.true_output_oe[c] = 1'b1;
				next_s.pins.complementary_output_oe[c] = 1'b1;
			end
		end
	end

	// Synchronous reset also clears the lock
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			s     <= '0;
			s.bdt <= `BDT_RESET;
		end
		else
			s <= next_s;
	end

	assign rdata_out              = s.rdata;
	assign pins_out               = s.pins;
	assign main_output_enable_out = s.bdt[`BDT_MAIN_OE_BIT];

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	sequence bdt_write;
		reg_req_in.wr && reg_req_in.addr == `BREAK_DEADTIME_CONTROL_ADDR;
	endsequence

	property p_lock_frozen;
		s.bdt_written and bdt_write |=> $stable(s.bdt[9:8]);
	endproperty
	a_lock_frozen: assert property (p_lock_frozen) // (R12)
		else $error("lock changed after first write");

	property p_dt_unlocked;
		s.bdt[9:8] == 2'b00 and bdt_write
			|=> s.bdt[7:0] == $past(reg_req_in.wdata[7:0]);
	endproperty
	a_dt_unlocked: assert property (p_dt_unlocked) // (R8)
		else $error("dead time not written while unlocked");

	property p_dt_locked;
		s.bdt[9:8] != 2'b00 |=> $stable(s.bdt[7:0]);
	endproperty
	a_dt_locked: assert property (p_dt_locked) // (R16)
		else $error("dead time changed under lock");

	property p_off_locked;
		s.bdt[9] |=> $stable(s.bdt[11:10]);
	endproperty
	a_off_locked: assert property (p_off_locked) // (R7)
		else $error("off-state bits changed at level 2");

	property p_idle_locked;
		s.bdt[9:8] != 2'b00 |=> $stable(s.idle_state) &&
			$stable(s.bdt[14:12]);
	endproperty
	a_idle_locked: assert property (p_idle_locked) // (R9)
		else $error("level 1 field changed");

	property p_pol_locked;
		s.bdt[9] && is_output(s.chan_mode, 0) |=> $stable(s.chan_enable[1]);
	endproperty
	a_pol_locked: assert property (p_pol_locked) // (R10)
		else $error("polarity changed at level 2");

	property p_mode_locked;
		s.bdt[9:8] == 2'b11 && is_output(s.chan_mode, 0)
			|=> $stable(s.chan_mode[6:3]);
	endproperty
	a_mode_locked: assert property (p_mode_locked) // (R11)
		else $error("compare mode changed at level 3");

	property p_break_moe;
		s.bdt[12] && break_in == s.bdt[13] |=> !main_output_enable_out;
	endproperty
	a_break_moe: assert property (p_break_moe) // (R18)
		else $error("break did not clear main enable");

	property p_idle_off;
		!s.bdt[15] && !s.bdt[10] |=> pins_out.true_output_oe == 3'b000 &&
			pins_out.complementary_output_oe == 3'b000;
	endproperty
	a_idle_off: assert property (p_idle_off) // (R6)
		else $error("outputs enabled in idle off-state 0");

endmodule : output_protection

/* File: logic/prot_params.svh */
// Offsets, field positions, reset values and timing of output protection
`ifndef PROT_PARAMS_SVH
`define PROT_PARAMS_SVH

// Register byte offsets, 16-bit registers
`define TIMER_CONTROL_TWO_ADDR        8'h04
`define CHANNEL_MODE_ONE_ADDR         8'h18
`define CHANNEL_MODE_TWO_ADDR         8'h1C
`define CHANNEL_ENABLE_ADDR           8'h20
`define BREAK_DEADTIME_CONTROL_ADDR   8'h44

// Break/dead-time field positions
`define BDT_DTG_LSB       0
`define BDT_LOCK_LSB      8
`define BDT_IDLE_OFF_BIT  10
`define BDT_RUN_OFF_BIT   11
`define BDT_BRK_EN_BIT    12
`define BDT_BRK_POL_BIT   13
`define BDT_AUTO_OE_BIT   14
`define BDT_MAIN_OE_BIT   15

// Idle state bits sit at 8 upward in control register two
`define IDLE_STATE_LSB    8

// Reset values
`define BDT_RESET         16'h0000
`define REG_RESET         16'h0000

// Dead-time tick and clock, in ns
`define CLK_PERIOD_NS         25
`define DEADTIME_TICK_NS      25
`define DEADTIME_TICK_CYCLES \
	((`DEADTIME_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define CHANNEL_COUNT     3

`endif

/* File: logic/prot_pkg.sv */
// Types shared by the output protection block
package prot_pkg;

	// Register port request
	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_type;

	// Pin group for the channel outputs
	typedef struct packed {
		logic [2:0] true_output;
		logic [2:0] complementary_output;
		logic [2:0] true_output_oe;
		logic [2:0] complementary_output_oe;
	} pin_group_type;

	// Dead-time inserter state
	typedef struct packed {
		logic       prev_ref;
		logic [9:0] cnt;
		logic       true_level;
		logic       compl_level;
	} dt_state_type;

	// Whole state of the protection block
	typedef struct packed {
		logic [15:0]   bdt;
		logic          bdt_written;
		logic [5:0]    idle_state;
		logic [11:0]   chan_enable;
		logic [23:0]   chan_mode;
		logic [15:0]   rdata;
		logic [9:0]    dt_cycles;
		pin_group_type pins;
	} prot_state_type;

endpackage : prot_pkg

/* File: verification/power_stage_model.sv */
// Gate driver model for the complementary power stage
module power_stage_model
	import prot_pkg::*;
(
	input  wire logic          clk_in,
	input  wire logic          rstn_in,
	input  wire pin_group_type pins_in,
	output logic               shoot_through_out
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [2:0] high_on;
	logic [2:0] low_on;

	// High and low side gates conduct only while their pin is driven
	assign high_on = pins_in.true_output & pins_in.true_output_oe;
	assign low_on  = pins_in.complementary_output &
		pins_in.complementary_output_oe;

	// shoot-through detect
	// Sticky until reset, so the bench misses no one-cycle overlap after its last reset
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			shoot_through_out <= 1'b0;
		else if (|(high_on & low_on))
			shoot_through_out <= 1'b1;
	end
endmodule : power_stage_model

/* File: verification/tb_top.sv */
// Self-checking bench for the output protection block
`include "prot_params.svh"

module tb_top
	import prot_pkg::*;
;
	timeunit 1ns;
	// Fine enough to keep the half period at 12.5 ns
	timeprecision 100ps;

	logic          clk_in    = 1'b0;
	logic          rstn_in   = 1'b0;
	reg_req_type   req       = '0;
	logic [2:0]    ref_wave  = 3'h0;
	logic          brk       = 1'b0;
	logic          upd       = 1'b0;
	logic [15:0]   rdata;
	logic [15:0]   rdata_nc;
	logic [15:0]   v;
	pin_group_type pins;
	logic          main_output_enable;
	logic          shoot;
	int            bad_count = 0;
	int            n_tests   = 0;
	logic [15:0]   lk_bdt [4] = '{16'h4CFF, 16'h0D00, 16'h0200, 16'h0300};
	logic [15:0]   os_bdt [4] = '{16'h8800, 16'h8000, 16'h0400, 16'h0000};
	logic [5:0]    os_oe  [4] = '{6'h09, 6'h08, 6'h09, 6'h00};

	////////////////////////////////////////////////////////////////////////
	// Clock, design and partner
	initial
	begin
		forever #12.5 clk_in = ~clk_in;
	end

	output_protection output_protection_i (
		.clk_in                 (clk_in),
		.rstn_in                (rstn_in),
		.reg_req_in             (req),
		.ref_in                 (ref_wave),
		.break_in               (brk),
		.update_event_in        (upd),
		.rdata_out              (rdata),
		.pins_out               (pins),
		.main_output_enable_out (main_output_enable)
	);

	// Variant without complementary outputs shares the same requests
	output_protection #(.has_complementary(1'b0)) output_protection_nc_i (
		.clk_in                 (clk_in),
		.rstn_in                (rstn_in),
		.reg_req_in             (req),
		.ref_in                 (ref_wave),
		.break_in               (brk),
		.update_event_in        (upd),
		.rdata_out              (rdata_nc),
		.pins_out               (),
		.main_output_enable_out ()
	);

	power_stage_model power_stage_model_i (
		.clk_in            (clk_in),
		.rstn_in           (rstn_in),
		.pins_in           (pins),
		.shoot_through_out (shoot)
	);

	////////////////////////////////////////////////////////////////////////
	// Tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict;
		if (bad_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict

	task automatic do_reset;
		@(posedge clk_in);
		rstn_in <= 1'b0;
		repeat (12) @(posedge clk_in);
		rstn_in <= 1'b1;
	endtask : do_reset

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		req.addr  <= a;
		req.wdata <= d;
		req.wr    <= 1'b1;
		@(posedge clk_in);
		req.wr    <= 1'b0;
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_in);
		req.addr <= a;
		req.rd   <= 1'b1;
		@(posedge clk_in);
		req.rd   <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg

	// Pins lag a register write by two cycles
	task automatic settle;
		repeat (3) @(posedge clk_in);
		#1;
	endtask : settle

	// Cycles from a ref edge until the rising output turns on
	task automatic meas_edge(input logic rise, input int dt);
		int n;
		@(posedge clk_in);
		ref_wave <= {2'b00, rise};
		@(posedge clk_in);
		#1;
		// One edge has passed since the ref launch
		n = 1;
		while ((rise ? pins.true_output[0] : pins.complementary_output[0])
			!== 1'b1 && n < 1100)
		begin
			@(posedge clk_in);
			#1;
			n++;
		end
		check(16'(n), 16'(dt + 2));
	endtask : meas_edge

	task automatic meas(input logic [7:0] code, input int dt);
		wr_reg(`BREAK_DEADTIME_CONTROL_ADDR, {8'h80, code});
		repeat (dt + 8) @(posedge clk_in);
		meas_edge(1'b1, dt);
		check({15'h0, pins.complementary_output[0]}, 16'h0000);
		repeat (dt + 8) @(posedge clk_in);
		meas_edge(1'b0, dt);
		check({15'h0, pins.true_output[0]}, 16'h0000);
	endtask : meas

	////////////////////////////////////////////////////////////////////////
	// Watchdog against a hang
	initial
	begin
		repeat (30000) @(posedge clk_in);
		bad_count++;
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		do_reset();
		rd_reg(`BREAK_DEADTIME_CONTROL_ADDR, v);
		check(v, 16'h0000);
		rd_reg(8'h08, v);
		check(v, 16'h0000);
		// Lock levels: first write sets the level, second probes it
		for (int lvl = 0; lvl < 4; lvl++)
		begin
			do_reset();
			wr_reg(`BREAK_DEADTIME_CONTROL_ADDR, 16'(lvl) << 8);
			wr_reg(`BREAK_DEADTIME_CONTROL_ADDR, 16'h4FFF);
			rd_reg(`BREAK_DEADTIME_CONTROL_ADDR, v);
			check(v, lk_bdt[lvl]);
			wr_reg(`TIMER_CONTROL_TWO_ADDR, 16'h3F00);
			rd_reg(`TIMER_CONTROL_TWO_ADDR, v);
			check(v, lvl == 0 ? 16'h3F00 : 16'h0000);
			wr_reg(`CHANNEL_ENABLE_ADDR, 16'h0AAA);
			rd_reg(`CHANNEL_ENABLE_ADDR, v);
			check(v, lvl < 2 ? 16'h0AAA : 16'h0000);
			wr_reg(`CHANNEL_MODE_ONE_ADDR, 16'h7878);
			rd_reg(`CHANNEL_MODE_ONE_ADDR, v);
			check(v, lvl < 3 ? 16'h7878 : 16'h0000);
		end
		// Off-states with only the true output of channel one enabled
		do_reset();
		wr_reg(`TIMER_CONTROL_TWO_ADDR, 16'h0100);
		wr_reg(`CHANNEL_ENABLE_ADDR, 16'h0001);
		rd_reg(`BREAK_DEADTIME_CONTROL_ADDR, v);
		check(v, 16'h0000);
		for (int i = 0; i < 4; i++)
		begin
			wr_reg(`BREAK_DEADTIME_CONTROL_ADDR, os_bdt[i]);
			settle();
			v = {10'h0, pins.true_output_oe, pins.complementary_output_oe};
			check(v, {10'h0, os_oe[i]});
		end
		wr_reg(`BREAK_DEADTIME_CONTROL_ADDR, 16'h0400);
		settle();
		v = {14'h0, pins.true_output[0], pins.complementary_output[0]};
		check(v, 16'h0002);
		wr_reg(`BREAK_DEADTIME_CONTROL_ADDR, 16'h8800);
		rd_reg(`BREAK_DEADTIME_CONTROL_ADDR, v);
		check(v, 16'h8800);
		check(rdata_nc, 16'h8000);
		// Break clears main enable, update event restores it
		wr_reg(`BREAK_DEADTIME_CONTROL_ADDR, 16'hB000);
		settle();
		check({15'h0, main_output_enable}, 16'h0001);
		@(posedge clk_in);
		brk <= 1'b1;
		@(posedge clk_in);
		#1;
		check({15'h0, main_output_enable}, 16'h0000);
		@(posedge clk_in);
		brk <= 1'b0;
		wr_reg(`BREAK_DEADTIME_CONTROL_ADDR, 16'h7000);
		settle();
		check({15'h0, main_output_enable}, 16'h0000);
		@(posedge clk_in);
		upd <= 1'b1;
		@(posedge clk_in);
		upd <= 1'b0;
		settle();
		check({15'h0, main_output_enable}, 16'h0001);
		// Dead time over every range, both outputs of channel one
		do_reset();
		wr_reg(`CHANNEL_ENABLE_ADDR, 16'h0005);
		meas(8'h03, 3);
		meas(8'h7F, 127);
		meas(8'h81, 130);
		meas(8'hC1, 264);
		meas(8'hE1, 528);
		check({15'h0, shoot}, 16'h0000);
		print_verdict();
	end
endmodule : tb_top
